// file: rtl/cbx_exec.v
// Execution unit for conditional branches, pair loads and RAM/port transfers
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`include "cbx_defs.vh"

module cbx_exec (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        test_pin,
    input  wire        io_ack,
    input  wire [3:0]  io_rdata,
    output reg         io_req,
    output reg  [2:0]  io_kind,
    output reg  [7:0]  io_select,
    output reg  [3:0]  io_wdata
);

    localparam IO_IDLE = 2'b00;
    localparam IO_REQ  = 2'b01;
    localparam IO_DROP = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function two_word;
        input [7:0] word;
        begin
            two_word = word[7:4] == `CBX_OP_JUMP_COND
                    || word[7:4] == `CBX_OP_ISZ
                    || (word[7:4] == `CBX_OP_PAIR && !word[0]);
        end
    endfunction

    // Returns {valid, kind} for an operand in the transfer group
    function [3:0] io_decode;
        input [3:0] operand_field;
        begin
            case (operand_field)
                `CBX_IO_RD_MAIN: io_decode = {1'b1, `CBX_KIND_RD_MAIN};
                `CBX_IO_RD_ST0:  io_decode = {1'b1, `CBX_KIND_RD_ST0};
                `CBX_IO_RD_ST1:  io_decode = {1'b1, `CBX_KIND_RD_ST1};
                `CBX_IO_RD_ST2:  io_decode = {1'b1, `CBX_KIND_RD_ST2};
                `CBX_IO_RD_ROM:  io_decode = {1'b1, `CBX_KIND_RD_ROM};
                `CBX_IO_WR_MAIN: io_decode = {1'b1, `CBX_KIND_WR_MAIN};
                `CBX_IO_WR_ST0:  io_decode = {1'b1, `CBX_KIND_WR_ST0};
                `CBX_IO_WR_ST1:  io_decode = {1'b1, `CBX_KIND_WR_ST1};
                default:         io_decode = {1'b0, `CBX_KIND_RD_MAIN};
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0]  strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = new_val[b*8 +: 8];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    reg [11:0] pc;
    reg [3:0]  accumulator;
    reg        carry_link;
    reg [3:0]  idx [0:15];
    reg        pending;
    reg [7:0]  first_word;
    reg        taken_last;
    reg        unsupported;
    reg [1:0]  io_state;

    reg [5:0]  pin_s1;
    reg [5:0]  pin_s2;
    reg [5:0]  pin_s3;
    reg [5:0]  pin_f;

    wire        wr_fire;
    wire [7:0]  word;
    wire        instr_wr;
    wire [3:0]  isz_value;
    wire [11:0] br_next_pc;
    wire        br_taken;
    wire [3:0]  io_dec;
    wire [5:0]  agree;
    wire        test_f;
    wire        ack_f;
    wire [3:0]  rdata_f;
    wire [31:0] idx_lo;
    wire [31:0] idx_hi;
    wire [31:0] idx_lo_new;
    wire [31:0] idx_hi_new;
    wire [31:0] acc_new;
    wire [31:0] pc_new;
    reg  [31:0] rd_value;
    reg  [1:0]  rd_resp;
    integer     i;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
    assign word     = w_data[7:0];
    assign instr_wr = wr_fire && aw_addr == `CBX_ADDR_INSTR && w_strb[0]
                   && io_state == IO_IDLE;

    assign isz_value = idx[first_word[3:0]] + `CBX_NIB_ONE;
    assign io_dec    = io_decode(word[3:0]);

    assign test_f  = pin_f[5];
    assign ack_f   = pin_f[4];
    assign rdata_f = pin_f[3:0];

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_idx
            assign idx_lo[g*4 +: 4] = idx[g];
            assign idx_hi[g*4 +: 4] = idx[g+8];
        end
    endgenerate

    assign idx_lo_new = merge(idx_lo, w_data, w_strb);
    assign idx_hi_new = merge(idx_hi, w_data, w_strb);
    assign acc_new    = merge({27'h0, carry_link, accumulator}, w_data, w_strb);
    assign pc_new     = merge({20'h0, pc}, w_data, w_strb);

    cbx_branch u_branch (
        .pc_first    (pc),
        .first_word  (first_word),
        .addr_word   (word),
        .accumulator (accumulator),
        .carry_link  (carry_link),
        .test_low    (!test_f),
        .isz_value   (isz_value),
        .next_pc     (br_next_pc),
        .taken       (br_taken)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: a bit changes once stages two and three agree

    assign agree = ~(pin_s2 ^ pin_s3);

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= `CBX_PIN_RESET;
            pin_s2 <= `CBX_PIN_RESET;
            pin_s3 <= `CBX_PIN_RESET;
            pin_f  <= `CBX_PIN_RESET;
        end else begin
            pin_s1 <= {test_pin, io_ack, io_rdata};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= (pin_f & ~agree) | (pin_s3 & agree);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite channels

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CBX_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr > `CBX_ADDR_SELECT
                                 || aw_addr[1:0] != 2'h0)
                                ? `CBX_RESP_SLVERR : `CBX_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        rd_resp  = `CBX_RESP_OKAY;
        rd_value = 32'h0000_0000;
        case (s_axi_araddr)
            `CBX_ADDR_INSTR:  rd_value = {23'h0, pending, first_word};
            `CBX_ADDR_STATUS: rd_value = {27'h0, unsupported, test_f,
                                          taken_last, pending,
                                          io_state != IO_IDLE};
            `CBX_ADDR_PC:     rd_value = {20'h0, pc};
            `CBX_ADDR_ACC:    rd_value = {27'h0, carry_link, accumulator};
            `CBX_ADDR_IDX_LO: rd_value = idx_lo;
            `CBX_ADDR_IDX_HI: rd_value = idx_hi;
            `CBX_ADDR_SELECT: rd_value = {24'h0, io_select};
            default:          rd_resp  = `CBX_RESP_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `CBX_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_resp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction execution; hardware updates follow software writes so
    // that a transfer finishing in the same cycle keeps its result

    always @(posedge aclk) begin
        if (!aresetn) begin
            pc          <= `CBX_PC_RESET;
            accumulator <= `CBX_NIB_ZERO;
            carry_link  <= 1'b0;
            pending     <= 1'b0;
            first_word  <= 8'h00;
            taken_last  <= 1'b0;
            unsupported <= 1'b0;
            io_state    <= IO_IDLE;
            io_req      <= 1'b0;
            io_kind     <= `CBX_KIND_RD_MAIN;
            io_select   <= 8'h00;
            io_wdata    <= `CBX_NIB_ZERO;
            for (i = 0; i < 16; i = i + 1) begin
                idx[i] <= `CBX_NIB_ZERO;
            end
        end else begin
            if (wr_fire && aw_addr == `CBX_ADDR_PC) begin
                pc <= pc_new[11:0];
            end
            if (wr_fire && aw_addr == `CBX_ADDR_ACC) begin
                accumulator <= acc_new[3:0];
                carry_link  <= acc_new[4];
            end
            for (i = 0; i < 8; i = i + 1) begin
                if (wr_fire && aw_addr == `CBX_ADDR_IDX_LO) begin
                    idx[i] <= idx_lo_new[i*4 +: 4];
                end
                if (wr_fire && aw_addr == `CBX_ADDR_IDX_HI) begin
                    idx[i+8] <= idx_hi_new[i*4 +: 4];
                end
            end

            if (instr_wr && !pending) begin
                // Operation field in the upper nibble, operand in the lower
                unsupported <= 1'b0;
                if (two_word(word)) begin
                    pending    <= 1'b1;
                    first_word <= word;
                end else begin
                    pc <= pc + `CBX_PC_STEP_ONE;
                    if (word[7:4] == `CBX_OP_PAIR) begin
                        io_select <= {idx[{word[3:1], 1'b0}],
                                      idx[{word[3:1], 1'b1}]};
                    end else if (word[7:4] == `CBX_OP_IO && io_dec[3]) begin
                        // Selection stays put, so every transfer uses
                        // the last one sent
                        io_kind  <= io_dec[2:0];
                        io_wdata <= accumulator;
                        io_req   <= 1'b1;
                        io_state <= IO_REQ;
                    end else begin
                        unsupported <= 1'b1;
                    end
                end
            end else if (instr_wr) begin
                pending <= 1'b0;
                case (first_word[7:4])
                    `CBX_OP_JUMP_COND: begin
                        pc         <= br_next_pc;
                        taken_last <= br_taken;
                    end
                    `CBX_OP_ISZ: begin
                        idx[first_word[3:0]] <= isz_value;
                        pc         <= br_next_pc;
                        taken_last <= br_taken;
                    end
                    `CBX_OP_PAIR: begin
                        idx[{first_word[3:1], 1'b0}] <= word[7:4];
                        idx[{first_word[3:1], 1'b1}] <= word[3:0];
                        pc <= pc + `CBX_PC_STEP_TWO;
                    end
                    default: begin
                        pc <= pc + `CBX_PC_STEP_TWO;
                    end
                endcase
            end

            case (io_state)
                IO_REQ: begin
                    if (ack_f) begin
                        io_req   <= 1'b0;
                        io_state <= IO_DROP;
                        // Reads load the accumulator only; carry stays
                        if (io_kind < `CBX_KIND_FIRST_WR) begin
                            accumulator <= rdata_f;
                        end
                    end
                end
                IO_DROP: begin
                    // Wait for the chip to drop its ack so one request
                    // is never seen twice
                    if (!ack_f) begin
                        io_state <= IO_IDLE;
                    end
                end
                IO_IDLE: begin
                    // Must not undo a request started above
                end
                default: begin
                    io_state <= IO_IDLE;
                end
            endcase
        end
    end

endmodule

// file: rtl/cbx_defs.vh
// Constants shared by the branch and memory transfer execution unit
`ifndef CBX_DEFS_VH
`define CBX_DEFS_VH

// Register byte offsets on the AXI4-Lite bus
`define CBX_ADDR_INSTR      8'h00
`define CBX_ADDR_STATUS     8'h04
`define CBX_ADDR_PC         8'h08
`define CBX_ADDR_ACC        8'h0c
`define CBX_ADDR_IDX_LO     8'h10
`define CBX_ADDR_IDX_HI     8'h14
`define CBX_ADDR_SELECT     8'h18

`define CBX_RESP_OKAY       2'h0
`define CBX_RESP_SLVERR     2'h2

// Operation field codes
`define CBX_OP_JUMP_COND    4'h1
`define CBX_OP_PAIR         4'h2
`define CBX_OP_ISZ          4'h7
`define CBX_OP_IO           4'he

// Operand field codes inside the transfer group
`define CBX_IO_WR_MAIN      4'h0
`define CBX_IO_WR_ST0       4'h4
`define CBX_IO_WR_ST1       4'h5
`define CBX_IO_RD_MAIN      4'h9
`define CBX_IO_RD_ROM       4'ha
`define CBX_IO_RD_ST0       4'hc
`define CBX_IO_RD_ST1       4'hd
`define CBX_IO_RD_ST2       4'he

// Transfer kinds driven on io_kind; reads sort below CBX_KIND_FIRST_WR
`define CBX_KIND_RD_MAIN    3'h0
`define CBX_KIND_RD_ST0     3'h1
`define CBX_KIND_RD_ST1     3'h2
`define CBX_KIND_RD_ST2     3'h3
`define CBX_KIND_RD_ROM     3'h4
`define CBX_KIND_WR_MAIN    3'h5
`define CBX_KIND_WR_ST0     3'h6
`define CBX_KIND_WR_ST1     3'h7
`define CBX_KIND_FIRST_WR   3'h5

// Condition bit positions in the first word's operand field
`define CBX_COND_INVERT     3
`define CBX_COND_ACC_ZERO   2
`define CBX_COND_CARRY      1
`define CBX_COND_TEST_LOW   0

// Status register bit positions
`define CBX_ST_BUSY         0
`define CBX_ST_PENDING      1
`define CBX_ST_TAKEN        2
`define CBX_ST_TEST         3
`define CBX_ST_UNSUPP       4

`define CBX_PC_RESET        12'h000
`define CBX_PC_STEP_ONE     12'h001
`define CBX_PC_STEP_TWO     12'h002
`define CBX_NIB_ZERO        4'h0
`define CBX_NIB_ONE         4'h1
`define CBX_PIN_RESET       6'h20

`endif

// file: rtl/cbx_branch.v
// Jump decision and target address for the two-word branch instructions
`include "cbx_defs.vh"

module cbx_branch (
    input  wire [11:0] pc_first,
    input  wire [7:0]  first_word,
    input  wire [7:0]  addr_word,
    input  wire [3:0]  accumulator,
    input  wire        carry_link,
    input  wire        test_low,
    input  wire [3:0]  isz_value,
    output wire [11:0] next_pc,
    output wire        taken
);

    wire [11:0] seq_pc;
    wire [3:0]  cond;
    wire        any_true;
    wire        cond_jump;
    wire        isz_jump;

    assign seq_pc = pc_first + `CBX_PC_STEP_TWO;
    assign cond   = first_word[3:0];

    assign any_true = (cond[`CBX_COND_ACC_ZERO]
                       && accumulator == `CBX_NIB_ZERO)
                    || (cond[`CBX_COND_CARRY] && carry_link)
                    || (cond[`CBX_COND_TEST_LOW] && test_low);

    assign cond_jump = first_word[7:4] == `CBX_OP_JUMP_COND
                    && (any_true ^ cond[`CBX_COND_INVERT]);
    assign isz_jump  = first_word[7:4] == `CBX_OP_ISZ
                    && isz_value != `CBX_NIB_ZERO;

    assign taken = cond_jump || isz_jump;

    // Page comes from the address after the second word, so a pair at the
    // end of a page lands on the next page
    assign next_pc = taken ? {seq_pc[11:8], addr_word}
                           : seq_pc;

endmodule

// file: tb/cbx_exec_asserts.sv
// Port checks for the branch and transfer execution unit
`include "cbx_defs.vh"
module cbx_exec_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        io_ack,
    input wire logic        io_req,
    input wire logic [2:0]  io_kind,
    input wire logic [7:0]  io_select,
    input wire logic [3:0]  io_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    sequence both_in;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Ack crosses three flops and a filter before the request may fall
    sequence req_release;
        ##[1:8] !io_req;
    endsequence
    write_answer_a: assert property (both_in |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    b_stands_a: assert property (s_axi_bvalid |=> ($past(s_axi_bready)
        ? !s_axi_bvalid : s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("b dropped");
    r_stands_a: assert property (s_axi_rvalid |=> ($past(s_axi_rready)
        ? !s_axi_rvalid : s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("r dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    read_unmapped_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > `CBX_ADDR_SELECT |=> s_axi_rdata == 32'h0 &&
        s_axi_rresp == `CBX_RESP_SLVERR) else $error("unmapped read ok");
    req_hold_a: assert property (io_req && !io_ack |=> io_req)
        else $error("request dropped early");
    xfer_stable_a: assert property (io_req && $past(io_req)
        |-> $stable({io_kind, io_select, io_wdata})) else $error("unstable");
    req_release_a: assert property ($rose(io_ack) |-> req_release)
        else $error("request stuck");
    four_phase_a: assert property (!io_req && io_ack |=> !io_req)
        else $error("request while ack high");
endmodule

// file: tb/cbx_mem_model.sv
// Behavioural RAM and ROM chips on the far side of the transfer link
`include "cbx_defs.vh"
module cbx_mem_model (
    input  wire logic       aclk,
    input  wire logic       io_req,
    input  wire logic [2:0] io_kind,
    input  wire logic [7:0] io_select,
    input  wire logic [3:0] io_wdata,
    input  wire logic       slow,
    input  wire logic [3:0] rom_pins,
    output logic            io_ack,
    output logic [3:0]      io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    parameter logic [3:0] IN_MASK   = 4'h3;
    parameter logic [3:0] OUT_FIXED = 4'h8;
    logic [3:0] main_mem [0:255];
    logic [3:0] stat [0:2][0:15];
    logic [3:0] val;
    initial begin
        io_ack = 1'b0;
        io_rdata = 4'h0;
        for (int i = 0; i < 256; i++) main_mem[i] = 4'h0;
        for (int i = 0; i < 48; i++) stat[i / 16][i % 16] = i[3:0] ^ 4'h5;
        forever begin
            @(posedge aclk);
            if (io_req) begin
                repeat (slow ? 10 : 1) @(posedge aclk);
                val = io_wdata;
                case (io_kind)
                    `CBX_KIND_RD_MAIN: val = main_mem[io_select];
                    `CBX_KIND_RD_ROM: val = (rom_pins & IN_MASK) |
                        (OUT_FIXED & ~IN_MASK);
                    `CBX_KIND_WR_MAIN: main_mem[io_select] = io_wdata;
                    `CBX_KIND_WR_ST0, `CBX_KIND_WR_ST1:
                        stat[io_kind - 3'h6][io_select[7:4]] = io_wdata;
                    default: val = stat[io_kind - 3'h1][io_select[7:4]];
                endcase
                // Data settles a cycle before ack rises
                io_rdata <= val;
                @(posedge aclk);
                io_ack <= 1'b1;
                do @(posedge aclk); while (io_req);
                io_ack <= 1'b0;
                // Released lines show no stale value
                io_rdata <= ~val;
            end
        end
    end
endmodule

// file: tb/tb_cond_branch_and_mem_io_exec.sv
// Self-checking bench for the branch and transfer execution unit
`include "cbx_defs.vh"
module tb_cond_branch_and_mem_io_exec;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, test_pin, slow, io_ack, io_req;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic [2:0]  io_kind;
    logic [3:0]  io_rdata, io_wdata, rom_pins;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, io_select;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    int          n_mismatch, total_checks;
    cbx_exec dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .test_pin,
        .io_ack, .io_rdata, .io_req, .io_kind, .io_select, .io_wdata
    );
    cbx_mem_model mem (
        .aclk, .io_req, .io_kind, .io_select, .io_wdata, .slow, .rom_pins,
        .io_ack, .io_rdata
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string s);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h want %h", $time, s, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        last_resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        got = s_axi_rdata;
        last_resp = s_axi_rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string s);
        rd(a);
        chk(got, e, s);
    endtask
    task automatic ins(input logic [7:0] w);
        wr(`CBX_ADDR_INSTR, {24'h0, w});
    endtask
    task automatic op2(input logic [11:0] pc, input logic [7:0] w1, w2);
        wr(`CBX_ADDR_PC, {20'h0, pc});
        ins(w1);
        ins(w2);
    endtask
    // Later words are dropped while a transfer is busy
    task automatic xfer(input logic [7:0] w);
        ins(w);
        do rd(`CBX_ADDR_STATUS); while (got[`CBX_ST_BUSY] !== 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(`CBX_ADDR_PC, 32'h0, "pc");
        rchk(`CBX_ADDR_SELECT, 32'h0, "select");
        rd(8'h1c);
        chk({30'h0, last_resp}, {30'h0, `CBX_RESP_SLVERR}, "rresp");
        wr(8'h20, 32'h1);
        chk({30'h0, last_resp}, {30'h0, `CBX_RESP_SLVERR}, "bresp");
    endtask
    task automatic t_jump();
        logic [11:0] pc, e;
        logic [3:0]  acc;
        logic        cy, tst, sel;
        for (int s = 0; s < 4; s++) begin
            acc = (s == 0) ? 4'h0 : 4'h3;
            cy = (s == 1);
            tst = (s != 2);
            pc = (s == 3) ? 12'h3fe : 12'h1a0;
            test_pin <= tst;
            repeat (8) @(posedge aclk);
            wr(`CBX_ADDR_ACC, {27'h0, cy, acc});
            for (int c = 0; c < 16; c++) begin
                op2(pc, {4'h1, c[3:0]}, 8'h5c);
                sel = (c[2] && acc == 4'h0) || (c[1] && cy) || (c[0] && !tst);
                e = pc + 12'h002;
                if (sel ^ c[3]) e = {e[11:8], 8'h5c};
                rd(`CBX_ADDR_STATUS);
                chk({31'h0, got[2]}, {31'h0, sel ^ c[3]}, "taken");
                rchk(`CBX_ADDR_PC, {20'h0, e}, "pc");
            end
        end
    endtask
    task automatic t_isz();
        wr(`CBX_ADDR_ACC, 32'h0000_001a);
        wr(`CBX_ADDR_IDX_LO, 32'h0070_f000);
        wr(`CBX_ADDR_IDX_HI, 32'h0002_0000);
        op2(12'h100, 8'h73, 8'h55);
        rchk(`CBX_ADDR_PC, 32'h0000_0102, "zero");
        op2(12'h5fe, 8'h75, 8'h21);
        rchk(`CBX_ADDR_PC, 32'h0000_0621, "page");
        op2(12'h200, 8'h7c, 8'h10);
        rchk(`CBX_ADDR_PC, 32'h0000_0210, "skip");
        rchk(`CBX_ADDR_IDX_LO, 32'h0080_0000, "wrap");
        rchk(`CBX_ADDR_IDX_HI, 32'h0003_0000, "hi");
        rchk(`CBX_ADDR_ACC, 32'h0000_001a, "acc");
    endtask
    task automatic t_pair();
        wr(`CBX_ADDR_IDX_LO, 32'h0);
        wr(`CBX_ADDR_IDX_HI, 32'h0);
        op2(12'h010, 8'h24, 8'hc3);
        op2(12'h020, 8'h2c, 8'h5a);
        rchk(`CBX_ADDR_IDX_LO, 32'h003c_0000, "lo");
        rchk(`CBX_ADDR_IDX_HI, 32'h00a5_0000, "hi");
        rchk(`CBX_ADDR_PC, 32'h0000_0022, "pc");
        ins(8'h2d);
        rchk(`CBX_ADDR_SELECT, 32'h0000_005a, "sel");
        ins(8'h25);
        rchk(`CBX_ADDR_SELECT, 32'h0000_00c3, "sel");
    endtask
    task automatic t_xfer();
        slow <= 1'b1;
        wr(`CBX_ADDR_ACC, 32'h0000_0019);
        wr(`CBX_ADDR_PC, 32'h0000_0300);
        ins(8'he0);
        xfer(8'h73);
        chk({28'h0, mem.main_mem[8'hc3]}, 32'h9, "main");
        rchk(`CBX_ADDR_PC, 32'h0000_0301, "busy");
        wr(`CBX_ADDR_ACC, 32'h0000_0016);
        xfer(8'he4);
        wr(`CBX_ADDR_ACC, 32'h0000_001b);
        xfer(8'he5);
        chk({28'h0, mem.stat[0][12]}, 32'h6, "st0");
        chk({28'h0, mem.stat[1][12]}, 32'hb, "st1");
        rchk(`CBX_ADDR_ACC, 32'h0000_001b, "acc");
        slow <= 1'b0;
        wr(`CBX_ADDR_ACC, 32'h0000_0010);
        xfer(8'he9);
        rchk(`CBX_ADDR_ACC, 32'h0000_0019, "main");
        xfer(8'hec);
        rchk(`CBX_ADDR_ACC, 32'h0000_0016, "st0");
        xfer(8'hed);
        rchk(`CBX_ADDR_ACC, 32'h0000_001b, "st1");
        xfer(8'hee);
        rchk(`CBX_ADDR_ACC, 32'h0000_0019, "st2");
        rom_pins <= 4'h7;
        xfer(8'hea);
        rchk(`CBX_ADDR_ACC, 32'h0000_001b, "rom");
        rom_pins <= 4'h4;
        xfer(8'hea);
        rchk(`CBX_ADDR_ACC, 32'h0000_0018, "rom");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        n_mismatch++;
        final_report();
    end
    initial begin
        {aresetn, slow, rom_pins, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
        test_pin = 1'b1;
        n_mismatch = 0;
        total_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_jump();
        t_isz();
        t_pair();
        t_xfer();
        final_report();
    end
endmodule

bind cbx_exec cbx_exec_asserts chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_ack, .io_req,
    .io_kind, .io_select, .io_wdata
);
